//--- rtl/charge_timer_test_bypass.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - timer is a 34-stage divider; 283 min only reached at chain end
// - switch one feeds the tick past 19 stages, 524288 times faster
// - switch one is on whenever battery sense is below lower threshold
// - with switch one, limits 71..283 min become about 8.1..32.3 ms
// - switch one during real charging is harmless; low sense forces trickle anyway
// - test modes need no extra pins; normal behaviour unchanged otherwise
// - switch two feeds the tick past 11 stages, 2048 times faster
// - switch two needs sense low and negative bias on select one together
// - with switch two, fast/trickle falls about 2.1..8.3 s after sense drops
// - switch 3A skips 5 sampling gate stages, sampling 32 times faster
// - switch 3B skips 11 holdoff stages, holdoff 2048 times faster
// - both switch three sections follow negative bias on select one
// - three select pins pick 71..283 min; all biased disables the timer
// - entering the sense window resets the timer and over-temperature latch
// - timer past its limit latches trickle until a reset pulse

// divider chain whose tick can enter at one of two later stages
module skip_counter #(
   parameter int WIDTH  = 34,
   parameter int SKIP_A = 19,
   parameter int SKIP_B = 11
) (
   input  wire logic             i_sys_clk,  // system clock
   input  wire logic             i_rstn,     // async reset, active low
   input  wire logic             i_tick,     // base tick
   input  wire logic             i_clear,    // synchronous clear
   input  wire logic             i_skip_a,   // bypass SKIP_A stages
   input  wire logic             i_skip_b,   // bypass SKIP_B stages, wins
   input  wire logic             i_sat,      // hold at all ones
   output logic [WIDTH-1:0]      o_count     // chain state
);
   logic [WIDTH-1:0] next_count;
   logic [WIDTH:0]   sum;
   logic [WIDTH:0]   step;

   // next chain value: tick injected at the bypass stage
   always_comb begin
      step = (WIDTH+1)'(1);
      if (i_skip_b) begin
         step = (WIDTH+1)'(1) << SKIP_B;
      end else if (i_skip_a) begin
         step = (WIDTH+1)'(1) << SKIP_A;
      end
      sum        = {1'b0, o_count} + step;
      next_count = o_count;
      if (i_clear) begin
         next_count = '0;
      end else if (i_tick) begin
         if (sum[WIDTH] && i_sat) begin
            next_count = '1;  // end of chain reached, stop
         end else begin
            next_count = sum[WIDTH-1:0];
         end
      end
   end

   // chain register
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_count <= '0;
      end else begin
         o_count <= next_count;
      end
   end
endmodule // skip_counter

module charge_timer_test_bypass
   import charge_timer_pkg::*;
#(
   parameter int TICK_CYC = BASE_TICK_CYC
) (
   input  wire logic i_sys_clk,             // 200 MHz clock
   input  wire logic i_rstn,                // async reset, active low
   input  wire logic i_sense_low,           // battery sense below lower threshold
   input  wire logic i_sense_in_window,     // battery sense inside fast window
   input  wire logic i_uvlo,                // supply undervoltage lockout
   input  wire logic i_limit_select_one,    // select one open (1) or grounded (0)
   input  wire logic i_limit_select_two,    // select two open (1) or grounded (0)
   input  wire logic i_limit_select_three,  // select three open (1) or grounded (0)
   input  wire logic i_limit_select_one_neg,// select one at negative bias
   input  wire logic i_temp_backup,         // all selects biased: timer disabled
   output logic      o_fast_allowed,        // timer permits fast charge
   output logic      o_timer_expired,       // latched trickle from timer
   output logic      o_reset_pulse,         // timer / over-temp latch reset
   output logic      o_sample_gate_output,  // sampling gate, low while sampling
   output logic      o_holdoff_done,        // trickle holdoff elapsed
   output logic      o_test_sw1,            // switch one engaged
   output logic      o_test_sw2,            // switch two engaged
   output logic      o_test_sw3             // switch three engaged
);
   import charge_timer_pkg::*;

   // synchroniser flops and their next values
   logic                      low_meta;
   logic                      low_sync;
   logic                      neg_meta;
   logic                      neg_sync;
   logic                      next_low_meta;
   logic                      next_low_sync;
   logic                      next_neg_meta;
   logic                      next_neg_sync;
   // switch flags
   logic                      sw1;
   logic                      sw2;
   logic                      sw3;
   logic                      next_sw1;
   logic                      next_sw2;
   logic                      next_sw3;
   // window edge detect and reset pulse
   logic                      win_q;
   logic                      next_win_q;
   logic                      rst_pulse;
   logic                      next_rst_pulse;
   // base tick prescaler
   logic [TICK_W-1:0]         tick_cnt;
   logic [TICK_W-1:0]         next_tick_cnt;
   logic                      tick;
   logic                      next_tick;
   // latched trickle and output flags
   logic                      expired;
   logic                      next_expired;
   logic                      fast;
   logic                      next_fast;
   logic                      gate;
   logic                      next_gate;
   logic                      hold_done;
   logic                      next_hold_done;
   // limit decode and divider chains
   logic [LIMIT_W:0]          limit_steps;
   logic                      limit_hit;
   logic                      chain_clear;
   logic [CHAIN_STAGES-1:0]   chain;
   logic [SAMPLE_STAGES-1:0]  sample;
   logic [HOLDOFF_STAGES-1:0] holdoff;

   // two-flop synchronisers for analogue test conditions
   always_comb begin
      next_low_meta = i_sense_low;
      next_low_sync = low_meta;
      next_neg_meta = i_limit_select_one_neg;
      next_neg_sync = neg_meta;
   end

   // first flops may go metastable, so only the second flops feed the decode
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         low_meta <= 1'b0;
         low_sync <= 1'b0;
         neg_meta <= 1'b0;
         neg_sync <= 1'b0;
      end else begin
         low_meta <= next_low_meta;
         low_sync <= next_low_sync;
         neg_meta <= next_neg_meta;
         neg_sync <= next_neg_sync;
      end
   end

   // test switch decode from existing inputs only
   always_comb begin
      next_sw1 = low_sync;
      next_sw2 = low_sync && neg_sync;
      next_sw3 = neg_sync;
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sw1 <= 1'b0;
         sw2 <= 1'b0;
         sw3 <= 1'b0;
      end else begin
         sw1 <= next_sw1;
         sw2 <= next_sw2;
         sw3 <= next_sw3;
      end
   end

   // base tick prescaler standing in for the internal oscillator
   always_comb begin
      next_tick     = 1'b0;
      next_tick_cnt = tick_cnt + TICK_W'(1);
      if (tick_cnt >= TICK_W'(TICK_CYC - 1)) begin
         next_tick_cnt = '0;
         next_tick     = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick     <= next_tick;
      end
   end

   // reset pulse on window entry or while supply is locked out
   always_comb begin
      next_win_q     = i_sense_in_window;
      next_rst_pulse = (i_sense_in_window && !win_q) || i_uvlo;
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         win_q     <= 1'b0;
         rst_pulse <= 1'b0;
      end else begin
         win_q     <= next_win_q;
         rst_pulse <= next_rst_pulse;
      end
   end

   // chain restarts on a reset pulse and when switch one engages
   assign chain_clear = rst_pulse || (next_sw1 && !sw1) || i_temp_backup;

   // backup charge timer: 34 stages, switch two wins over switch one
   skip_counter #(
      .WIDTH  (CHAIN_STAGES),
      .SKIP_A (SW1_SKIP),
      .SKIP_B (SW2_SKIP)
   ) u_chain (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_tick    (tick),
      .i_clear   (chain_clear),
      .i_skip_a  (sw1),
      .i_skip_b  (sw2),
      .i_sat     (1'b1),
      .o_count   (chain)
   );

   // sampling gate divider, section A of switch three
   skip_counter #(
      .WIDTH  (SAMPLE_STAGES),
      .SKIP_A (SW3A_SKIP),
      .SKIP_B (SW3A_SKIP)
   ) u_sample (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_tick    (tick),
      .i_clear   (1'b0),
      .i_skip_a  (sw3),
      .i_skip_b  (1'b0),
      .i_sat     (1'b0),
      .o_count   (sample)
   );

   // trickle holdoff timer, section B of switch three
   skip_counter #(
      .WIDTH  (HOLDOFF_STAGES),
      .SKIP_A (SW3B_SKIP),
      .SKIP_B (SW3B_SKIP)
   ) u_holdoff (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_tick    (tick),
      .i_clear   (rst_pulse),
      .i_skip_a  (sw3),
      .i_skip_b  (1'b0),
      .i_sat     (1'b1),
      .o_count   (holdoff)
   );

   // programmed limit from the open/grounded selects
   always_comb begin
      limit_steps = {1'b0, i_limit_select_three, i_limit_select_two, i_limit_select_one}
                    + (LIMIT_W+1)'(1);
      if (limit_steps < LIMIT_STEPS_MIN) begin
         limit_steps = LIMIT_STEPS_MIN;
      end
      if (limit_steps == LIMIT_STEPS_MAX) begin
         limit_hit = &chain;  // only at end of chain
      end else begin
         limit_hit = {1'b0, chain[CHAIN_STAGES-1:LIMIT_LSB]} >= limit_steps;
      end
   end

   // latched trickle and output flags
   always_comb begin
      next_expired = expired;
      if (rst_pulse) begin
         next_expired = 1'b0;  // only a reset pulse releases
      end else if (limit_hit && !i_temp_backup) begin
         next_expired = 1'b1;
      end
      next_fast      = !next_expired && !i_uvlo;
      next_gate      = |sample[SAMPLE_STAGES-1:SW3A_SKIP];  // low near wrap
      next_hold_done = holdoff[HOLDOFF_STAGES-1];
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         expired   <= EXPIRED_RST;
         fast      <= 1'b0;
         gate      <= 1'b1;
         hold_done <= 1'b0;
      end else begin
         expired   <= next_expired;
         fast      <= next_fast;
         gate      <= next_gate;
         hold_done <= next_hold_done;
      end
   end

   // outputs straight from flops
   assign o_fast_allowed       = fast;
   assign o_timer_expired      = expired;
   assign o_reset_pulse        = rst_pulse;
   assign o_sample_gate_output = gate;
   assign o_holdoff_done       = hold_done;
   assign o_test_sw1           = sw1;
   assign o_test_sw2           = sw2;
   assign o_test_sw3           = sw3;
endmodule // charge_timer_test_bypass
`default_nettype wire

//--- rtl/charge_timer_pkg.sv
`default_nettype none
package charge_timer_pkg;
   // timer chain geometry
   localparam int CHAIN_STAGES    = 34;
   localparam int SW1_SKIP        = 19;
   localparam int SW2_SKIP        = 11;
   localparam int LIMIT_LSB       = 31;  // one limit step = 2**31 base ticks
   localparam int LIMIT_W         = 3;
   localparam logic [LIMIT_W:0] LIMIT_STEPS_MAX = 4'h8;  // 283 min, end of chain
   localparam logic [LIMIT_W:0] LIMIT_STEPS_MIN = 4'h2;  // 71 min
   // sampling gate divider and holdoff timer
   localparam int SAMPLE_STAGES   = 21;
   localparam int SW3A_SKIP       = 5;
   localparam int HOLDOFF_STAGES  = 28;
   localparam int SW3B_SKIP       = 11;
   // timing: base tick derived from the longest limit over the whole chain
   localparam longint SYS_CLK_PS      = 5000;
   localparam longint LIMIT_MAX_MIN   = 283;
   // picoseconds per second need more than 32 bits, so the literal is sized
   localparam longint BASE_TICK_PS    = (LIMIT_MAX_MIN * 60 * 64'he8d4a51000) / (64'h1 << CHAIN_STAGES);
   localparam int     BASE_TICK_CYC   = int'(BASE_TICK_PS / SYS_CLK_PS);  // round down, 197
   localparam int     TICK_W          = 16;
   // reset values
   localparam logic   EXPIRED_RST     = 1'b0;
endpackage
`default_nettype wire

//--- bench/charge_timer_test_bypass_sva.sv
`timescale 1ns/1ps
`default_nettype none
// watches the timer ports; all in one clock domain
module charge_timer_test_bypass_sva (
   input wire logic i_sys_clk,              // clock
   input wire logic i_rstn,                 // reset, active low
   input wire logic i_sense_low,            // sense low
   input wire logic i_sense_in_window,      // sense in window
   input wire logic i_uvlo,                 // lockout
   input wire logic i_limit_select_one,     // select one
   input wire logic i_limit_select_two,     // select two
   input wire logic i_limit_select_three,   // select three
   input wire logic i_limit_select_one_neg, // negative bias
   input wire logic i_temp_backup,          // timer disabled
   input wire logic o_fast_allowed,         // fast permitted
   input wire logic o_timer_expired,        // latched trickle
   input wire logic o_reset_pulse,          // reset pulse
   input wire logic o_sample_gate_output,   // sampling gate
   input wire logic o_holdoff_done,         // holdoff over
   input wire logic o_test_sw1,             // switch one
   input wire logic o_test_sw2,             // switch two
   input wire logic o_test_sw3              // switch three
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // switch flags follow their synchronised causes
   a_sw1_on_low: assert property (i_sense_low [*4] |-> o_test_sw1)
      else $error("switch one not engaged");
   a_sw1_off_high: assert property (!i_sense_low [*4] |-> !o_test_sw1)
      else $error("switch one engaged without cause");
   a_sw2_needs_both: assert property (o_test_sw2 |-> $past(i_sense_low, 3) && $past(i_limit_select_one_neg, 3))
      else $error("switch two engaged without both causes");
   a_sw3_on_neg: assert property (i_limit_select_one_neg [*4] |-> o_test_sw3)
      else $error("switch three not engaged");
   // reset pulse and latched trickle
   a_pulse_on_entry: assert property ($rose(i_sense_in_window) |-> ##1 o_reset_pulse)
      else $error("no reset pulse on window entry");
   a_expired_latched: assert property (o_timer_expired && !o_reset_pulse |=> o_timer_expired)
      else $error("latched trickle dropped without pulse");
   a_pulse_clears: assert property (o_reset_pulse |=> !o_timer_expired)
      else $error("reset pulse left trickle latched");
   a_expired_no_fast: assert property (o_timer_expired |-> !o_fast_allowed)
      else $error("fast permitted while expired");
   a_uvlo_no_fast: assert property (i_uvlo |=> !o_fast_allowed && o_reset_pulse)
      else $error("fast permitted during lockout");
   c_sw1: cover property (o_test_sw1 && !o_test_sw2);
   c_sw2: cover property (o_test_sw2);
   c_expire: cover property ($rose(o_timer_expired));
   c_holdoff: cover property ($rose(o_holdoff_done));
   c_gate_fast: cover property (o_test_sw3 && !o_sample_gate_output);
endmodule // charge_timer_test_bypass_sva
`default_nettype wire

//--- bench/tb_charge_timer_test_bypass.sv
`timescale 1ns/1ps
`default_nettype none
module tb_charge_timer_test_bypass;
   import charge_timer_pkg::*;
   localparam int TICK = 1;  // one base tick per clock keeps the holdoff run short
   localparam int EXP_CYC = 2 * (1 << (LIMIT_LSB - SW1_SKIP)) * TICK;  // k=2 with switch one
   localparam int HOLD_CYC = (1 << (HOLDOFF_STAGES - 1 - SW3B_SKIP)) * TICK;  // holdoff msb with 3B
   localparam int GATE_CYC = (1 << (SAMPLE_STAGES - SW3A_SKIP)) * TICK;  // gate period with 3A
   logic clk, rstn, low, win, uvlo, s1, s2, s3, neg, tb;
   logic fast, expd, pulse, gate, hold, sw1, sw2, sw3;
   int fail_count, compares, cnt, lows;
   int cycles = 0;
   charge_timer_test_bypass #(.TICK_CYC(TICK)) dut_u (
      .i_sys_clk(clk), .i_rstn(rstn), .i_sense_low(low), .i_sense_in_window(win),
      .i_uvlo(uvlo), .i_limit_select_one(s1), .i_limit_select_two(s2),
      .i_limit_select_three(s3), .i_limit_select_one_neg(neg), .i_temp_backup(tb),
      .o_fast_allowed(fast), .o_timer_expired(expd), .o_reset_pulse(pulse),
      .o_sample_gate_output(gate), .o_holdoff_done(hold), .o_test_sw1(sw1),
      .o_test_sw2(sw2), .o_test_sw3(sw3));
   // clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard: the scenarios need about 85000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // main sequence
   initial begin
      {rstn, low, win, uvlo, s2, s3, neg, tb} = 8'h00;
      s1 = 1'b1;
      fail_count = 0;
      compares = 0;
      cyc(10);
      check({fast, expd, gate}, 3'b001);
      rstn = 1'b1;
      cyc(2);
      win = 1'b1;
      cyc(4);
      check(fast, 1'b1);
      // every switch entry condition
      for (int i = 0; i < 4; i++) begin
         {low, neg} = i[1:0];
         cyc(5);
         check({sw1, sw2, sw3}, {low, low & neg, neg});
      end
      {low, neg} = 2'b00;
      cyc(2000);
      check({fast, expd}, 2'b10);
      // switch one: time to fast falling
      low = 1'b1;
      cnt = 0;
      while (fast === 1'b1 && cnt < EXP_CYC + 100) begin
         cyc(1);
         cnt++;
      end
      check(cnt >= EXP_CYC && cnt <= EXP_CYC + 12, 1'b1);
      check(expd, 1'b1);
      low = 1'b0;
      cyc(100);
      check({fast, expd}, 2'b01);
      // re-entry of the window releases the latch
      win = 1'b0;
      cyc(2);
      win = 1'b1;
      cyc(1);
      check(pulse, 1'b1);
      cyc(3);
      check({fast, expd, pulse}, 3'b100);
      // lockout
      uvlo = 1'b1;
      cyc(2);
      check({fast, pulse}, 2'b01);
      uvlo = 1'b0;
      cyc(4);
      // disabled timer never expires
      tb = 1'b1;
      low = 1'b1;
      cyc(EXP_CYC + 500);
      check(expd, 1'b0);
      // switch three speeds gate and holdoff; switch two keeps expiry far away
      tb = 1'b0;
      neg = 1'b1;
      cyc(5);
      check({sw1, sw2, sw3}, 3'b111);
      uvlo = 1'b1;
      cyc(1);
      uvlo = 1'b0;
      cnt = 0;
      lows = 0;
      while (hold !== 1'b1 && cnt < HOLD_CYC + 100) begin
         cyc(1);
         cnt++;
         if (cnt <= GATE_CYC && gate === 1'b0) begin
            lows++;
         end
      end
      check(cnt >= HOLD_CYC && cnt <= HOLD_CYC + 8, 1'b1);
      check(lows, 1);
      check(expd, 1'b0);
      finish_test();
   end
endmodule // tb_charge_timer_test_bypass
bind charge_timer_test_bypass charge_timer_test_bypass_sva sva_u (
   .i_sys_clk              (i_sys_clk),
   .i_rstn                 (i_rstn),
   .i_sense_low            (i_sense_low),
   .i_sense_in_window      (i_sense_in_window),
   .i_uvlo                 (i_uvlo),
   .i_limit_select_one     (i_limit_select_one),
   .i_limit_select_two     (i_limit_select_two),
   .i_limit_select_three   (i_limit_select_three),
   .i_limit_select_one_neg (i_limit_select_one_neg),
   .i_temp_backup          (i_temp_backup),
   .o_fast_allowed         (o_fast_allowed),
   .o_timer_expired        (o_timer_expired),
   .o_reset_pulse          (o_reset_pulse),
   .o_sample_gate_output   (o_sample_gate_output),
   .o_holdoff_done         (o_holdoff_done),
   .o_test_sw1             (o_test_sw1),
   .o_test_sw2             (o_test_sw2),
   .o_test_sw3             (o_test_sw3)
);
`default_nettype wire
